// ---- rtl/dlf_flasher.sv ----
// status indicator sequencer: self-test progress, ready blink and error code flashing
//
// Overview of operation
// [RL1] Any reset lights the status LED and holds it on during self-test.
// [RL2] Self-test ends about three seconds after reset; then configuration is accepted.
// [RL3] After a passed self-test the LED blinks evenly until configuration arrives.
// [RL4] Once configuration is accepted the LED goes off and stays off.
// [RL5] A hardware problem holds the LED steadily on or flashes its error code.
// [RL6] Error codes are eight bits, sent one bit at a time, msb first.
// [RL7] A one bit is a long pulse, a zero bit a short pulse.
// [RL8] The code repeats forever with a pause marking its first bit.
// [RL9] Warning codes 70H to 72H are shown while self-test keeps running.
// [RL10] Groups: configuration A0H-AFH; hardware 88H, B0H-BFH; run-time 91H, C0H-CFH, F0H.
// [RL11] Run-time codes are taken only in normal operation, never during self-test.
// [RL12] Code F0H is followed by four fault location bytes, high byte first.
// [RL13] Self-test failure is reported in the status bytes of host ports A and B.
// [RL14] A question mark from the terminal returns the shown code as text, 9600 7N1.
// [RL15] 70H fuse failure, 71H loopback failure, 72H negative supply failure.
// [RL16] A0H to AEH flag invalid configuration parameters.
// [RL17] B1H to BEH flag failed component tests.
// [RL18] C0H to CFH are run-time faults such as timeouts and sync loss.
// [RL19] Pulse, gap, pause and blink durations are parameters.
`timescale 1ns/1ps
`include "dlf_params.svh"

module dlf_flasher #(
  parameter logic [31:0] TEST_CYC  = `DLF_TEST_MS * `DLF_CYC_PER_MS,
  parameter logic [31:0] LONG_CYC  = `DLF_LONG_MS * `DLF_CYC_PER_MS,
  parameter logic [31:0] SHORT_CYC = `DLF_SHORT_MS * `DLF_CYC_PER_MS,
  parameter logic [31:0] GAP_CYC   = `DLF_GAP_MS * `DLF_CYC_PER_MS,
  parameter logic [31:0] PAUSE_CYC = `DLF_PAUSE_MS * `DLF_CYC_PER_MS,
  parameter logic [31:0] BLINK_CYC = `DLF_BLINK_MS * `DLF_CYC_PER_MS,
  parameter logic [31:0] BAUD_CYC  = `DLF_BAUD_CYC
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             hostSwRst,
  input  wire logic             cfgAccepted,
  input  wire dlf_pkg::dlf_err_t errIn,
  input  wire logic             uartRxd,
  output logic                  status_led,
  output logic [7:0]            portAStatus,
  output logic [7:0]            portBStatus,
  output logic                  uartTxd
);
  import dlf_pkg::*;

  dlf_state_t  state_q;
  dlf_phase_t  phase_q;
  logic [31:0] testCnt_q;
  logic [31:0] tmr_q;
  logic [31:0] blinkCnt_q;
  logic        blink_q;
  logic        show_q;
  logic        steady_q;
  logic        fail_q;
  logic [7:0]  code_q;
  logic [31:0] loc_q;
  logic [7:0]  shift_q;
  logic [2:0]  bitIdx_q;
  logic [2:0]  byteIdx_q;
  logic [2:0]  lastByte_q;
  logic        msgBusy_q;
  logic [1:0]  msgIdx_q;
  logic        txReady;
  logic        rxValid;
  logic [6:0]  rxData;

  // group decode of an error code
  function automatic dlf_class_t codeClass(input logic [7:0] c);
    if (c >= `DLF_WARN_LO && c <= `DLF_WARN_HI)
      return CL_WARN; // RL15
    else if (c[7:4] == `DLF_CFG_GROUP)
      return CL_CFG; // RL16
    else if (c[7:4] == `DLF_HW_GROUP || c == `DLF_HW_SINGLE)
      return CL_HW; // RL17
    else if (c[7:4] == `DLF_RUN_GROUP || c == `DLF_RUN_SINGLE || c == `DLF_SEGV_CODE)
      return CL_RUN; // RL18
    else
      return CL_NONE;
  endfunction

  // byte n of the flashed sequence: code, then fault location high byte first
  function automatic logic [7:0] seqByte(input logic [2:0] n, input logic [7:0] c,
                                         input logic [31:0] loc);
    unique case (n)
      3'h0:    return c;
      3'h1:    return loc[31:24]; // RL12
      3'h2:    return loc[23:16];
      3'h3:    return loc[15:8];
      default: return loc[7:0];
    endcase
  endfunction

  function automatic logic [6:0] hexChar(input logic [3:0] n);
    return (n < 4'hA) ? `DLF_ASCII_0 + {3'h0, n} : `DLF_ASCII_A + {3'h0, n};
  endfunction

  wire        rstAll   = sys_rst || hostSwRst; // RL1
  wire        testDone = (testCnt_q == TEST_CYC - 32'h1); // RL2
  dlf_class_t errClass;
  assign errClass = codeClass(errIn.code); // RL10

  // which errors each state takes
  wire takeWarn  = errIn.valid && state_q == ST_TEST && errClass == CL_WARN && !show_q; // RL9
  wire takeFatal = errIn.valid && state_q != ST_FAULT &&
                   (errClass == CL_CFG || errClass == CL_HW ||
                    (errClass == CL_RUN && state_q == ST_RUN)); // RL11
  wire startShow = takeWarn || (takeFatal && !errIn.steady);

  wire        tmrDone  = (tmr_q == 32'h0);
  wire        flashOn  = show_q && phase_q == PH_PULSE;
  wire        lastBit  = (bitIdx_q == 3'h0);
  wire        lastByte = (byteIdx_q == lastByte_q);
  wire [7:0]  nextByte = seqByte(byteIdx_q + 3'h1, code_q, loc_q);
  wire [31:0] bitLen0  = code_q[7] ? LONG_CYC : SHORT_CYC; // RL7

  logic ledD;
  always_comb
  begin
    unique case (state_q)
      ST_TEST:  ledD = show_q ? flashOn : 1'b1; // RL1
      ST_READY: ledD = blink_q; // RL3
      ST_RUN:   ledD = 1'b0; // RL4
      ST_FAULT: ledD = steady_q ? 1'b1 : flashOn; // RL5
    endcase
  end

  // top-level state
  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      state_q   <= ST_TEST;
      testCnt_q <= 32'h0;
      fail_q    <= 1'b0;
      steady_q  <= 1'b0;
    end
    else
    begin
      testCnt_q <= (state_q == ST_TEST) ? testCnt_q + 32'h1 : 32'h0;
      if (takeFatal)
      begin
        state_q  <= ST_FAULT;
        steady_q <= errIn.steady; // RL5
        fail_q   <= fail_q || state_q == ST_TEST; // RL13
      end
      else if (state_q == ST_TEST && testDone)
        state_q <= ST_READY; // RL2
      else if (state_q == ST_READY && cfgAccepted)
        state_q <= ST_RUN; // RL4
    end
  end

  // even blink while waiting for configuration
  always_ff @(posedge mclk)
  begin
    if (rstAll || state_q != ST_READY)
    begin
      blinkCnt_q <= 32'h0;
      blink_q    <= 1'b1;
    end
    else if (blinkCnt_q == BLINK_CYC - 32'h1)
    begin
      blinkCnt_q <= 32'h0;
      blink_q    <= !blink_q; // RL3
    end
    else
      blinkCnt_q <= blinkCnt_q + 32'h1;
  end

  // serial code flasher
  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      show_q     <= 1'b0;
      phase_q    <= PH_PAUSE;
      tmr_q      <= 32'h0;
      code_q     <= 8'h00;
      loc_q      <= 32'h0;
      shift_q    <= 8'h00;
      bitIdx_q   <= `DLF_BIT_MSB;
      byteIdx_q  <= 3'h0;
      lastByte_q <= `DLF_BYTES_PLAIN;
    end
    else if (startShow)
    begin
      show_q     <= 1'b1;
      code_q     <= errIn.code;
      loc_q      <= errIn.faultLoc;
      shift_q    <= errIn.code; // RL6
      bitIdx_q   <= `DLF_BIT_MSB;
      byteIdx_q  <= 3'h0;
      lastByte_q <= (errIn.code == `DLF_SEGV_CODE) ? `DLF_BYTES_SEGV : `DLF_BYTES_PLAIN; // RL12
      phase_q    <= PH_PAUSE; // RL8
      tmr_q      <= PAUSE_CYC - 32'h1;
    end
    else if (state_q == ST_TEST && testDone)
      show_q <= 1'b0;
    else if (show_q && !tmrDone)
      tmr_q <= tmr_q - 32'h1;
    else if (show_q)
    begin
      unique case (phase_q)
        PH_PULSE:
        begin
          phase_q <= PH_GAP;
          tmr_q   <= GAP_CYC - 32'h1;
        end
        PH_GAP:
          if (lastBit && lastByte)
          begin
            phase_q <= PH_PAUSE; // RL8
            tmr_q   <= PAUSE_CYC - 32'h1;
          end
          else
          begin
            phase_q   <= PH_PULSE;
            shift_q   <= lastBit ? nextByte : {shift_q[6:0], 1'b0}; // RL6
            byteIdx_q <= lastBit ? byteIdx_q + 3'h1 : byteIdx_q;
            bitIdx_q  <= bitIdx_q - 3'h1;
            tmr_q     <= ((lastBit ? nextByte[7] : shift_q[6]) ? LONG_CYC : SHORT_CYC)
                         - 32'h1; // RL7
          end
        PH_PAUSE:
        begin
          phase_q   <= PH_PULSE; // RL8
          shift_q   <= code_q;
          byteIdx_q <= 3'h0;
          bitIdx_q  <= `DLF_BIT_MSB;
          tmr_q     <= bitLen0 - 32'h1; // RL7
        end
      endcase
    end
  end

  // text answer to the terminal: two hex digits, CR, LF
  wire askSeen = rxValid && rxData == `DLF_ASK_CHAR && show_q; // RL14
  logic [6:0] msgChar;
  always_comb
  begin
    unique case (msgIdx_q)
      2'h0: msgChar = hexChar(code_q[7:4]);
      2'h1: msgChar = hexChar(code_q[3:0]);
      2'h2: msgChar = `DLF_ASCII_CR;
      2'h3: msgChar = `DLF_ASCII_LF;
    endcase
  end
  wire txSend = msgBusy_q && txReady;

  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      msgBusy_q <= 1'b0;
      msgIdx_q  <= 2'h0;
    end
    else if (askSeen && !msgBusy_q)
    begin
      msgBusy_q <= 1'b1; // RL14
      msgIdx_q  <= 2'h0;
    end
    else if (txSend)
    begin
      msgIdx_q  <= msgIdx_q + 2'h1;
      msgBusy_q <= (msgIdx_q != `DLF_MSG_LAST);
    end
  end

  dlf_serial_port #(
    .BIT_CYC (BAUD_CYC)
  ) uSerial (
    .mclk    (mclk),
    .sys_rst (rstAll),
    .rxdPin  (uartRxd),
    .txValid (txSend),
    .txData  (msgChar),
    .txReady (txReady),
    .rxValid (rxValid),
    .rxData  (rxData),
    .txdPin  (uartTxd)
  );

  // led and host status bytes
  logic [7:0] statD;
  always_comb
  begin
    statD                  = 8'h00;
    statD[`DLF_STAT_FAIL]  = fail_q; // RL13
    statD[`DLF_STAT_READY] = (state_q == ST_READY);
    statD[`DLF_STAT_BUSY]  = (state_q == ST_TEST);
    statD[`DLF_STAT_RUN]   = (state_q == ST_RUN);
  end

  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      status_led  <= 1'b1; // RL1
      portAStatus <= 8'h00;
      portBStatus <= 8'h00;
    end
    else
    begin
      status_led  <= ledD;
      portAStatus <= statD; // RL13
      portBStatus <= statD;
    end
  end

  // checks
  logic [31:0] onLen_q;
  always_ff @(posedge mclk)
  begin
    if (rstAll || !status_led)
      onLen_q <= 32'h0;
    else
      onLen_q <= onLen_q + 32'h1;
  end

  sequence s_pulse_end;
    state_q == ST_FAULT && !steady_q && $fell(status_led) && $past(flashOn, 2);
  endsequence

  sequence s_segv_start;
    startShow && errIn.code == `DLF_SEGV_CODE;
  endsequence

  a_reset_led_on: assert property (@(posedge mclk) rstAll |=> status_led) // RL1
    else $error("led not lit after reset");
  a_test_led_steady: assert property (@(posedge mclk) disable iff (rstAll) // RL1
    state_q == ST_TEST && !show_q |=> status_led)
    else $error("led dropped during self-test");
  a_cfg_to_off: assert property (@(posedge mclk) disable iff (rstAll) // RL4
    state_q == ST_READY && cfgAccepted && !takeFatal |=> state_q == ST_RUN ##1 !status_led)
    else $error("configuration did not turn led off");
  a_runtime_ignored: assert property (@(posedge mclk) disable iff (rstAll) // RL11
    state_q == ST_TEST && errIn.valid && errClass == CL_RUN |=> state_q != ST_FAULT)
    else $error("run-time code taken during self-test");
  a_warn_keeps_test: assert property (@(posedge mclk) disable iff (rstAll) // RL9
    takeWarn && !testDone |=> state_q == ST_TEST && show_q)
    else $error("warning stopped self-test");
  a_msb_first: assert property (@(posedge mclk) disable iff (rstAll) // RL6
    startShow |=> shift_q == $past(errIn.code) && bitIdx_q == `DLF_BIT_MSB
                  && phase_q == PH_PAUSE)
    else $error("code not started at msb");
  a_pulse_width: assert property (@(posedge mclk) disable iff (rstAll) // RL7
    s_pulse_end |-> $past(onLen_q) == LONG_CYC - 32'h1 || $past(onLen_q) == SHORT_CYC - 32'h1)
    else $error("pulse width neither long nor short");
  a_segv_bytes: assert property (@(posedge mclk) disable iff (rstAll) // RL12
    s_segv_start |=> lastByte_q == `DLF_BYTES_SEGV && loc_q == $past(errIn.faultLoc))
    else $error("fault location bytes not queued");
  a_fail_reported: assert property (@(posedge mclk) disable iff (rstAll) // RL13
    state_q == ST_TEST && takeFatal |=> ##1 portAStatus[`DLF_STAT_FAIL]
                                        && portBStatus[`DLF_STAT_FAIL])
    else $error("self-test failure not in port status");
  a_test_ends: assert property (@(posedge mclk) disable iff (rstAll) // RL2
    state_q == ST_TEST && testDone && !takeFatal |=> state_q == ST_READY)
    else $error("self-test did not end on time");

endmodule

// ---- rtl/dlf_params.svh ----
// timing, field and code constants for the status indicator flasher
`ifndef DLF_PARAMS_SVH
`define DLF_PARAMS_SVH

`define DLF_CLK_HZ       125000000
`define DLF_CYC_PER_MS   (`DLF_CLK_HZ / 1000)

`define DLF_TEST_MS      3000
`define DLF_LONG_MS      600
`define DLF_SHORT_MS     200
`define DLF_GAP_MS       400
`define DLF_PAUSE_MS     2000
`define DLF_BLINK_MS     500

`define DLF_BAUD         9600
`define DLF_BAUD_CYC     (`DLF_CLK_HZ / `DLF_BAUD)
`define DLF_SER_BITS     7
`define DLF_SER_LAST     3'h6
`define DLF_SER_FRAME    4'h8

`define DLF_ASK_CHAR     7'h3F
`define DLF_ASCII_0      7'h30
`define DLF_ASCII_A      7'h37
`define DLF_ASCII_CR     7'h0D
`define DLF_ASCII_LF     7'h0A
`define DLF_MSG_LAST     2'h3

`define DLF_WARN_LO      8'h70
`define DLF_WARN_HI      8'h72
`define DLF_HW_SINGLE    8'h88
`define DLF_RUN_SINGLE   8'h91
`define DLF_SEGV_CODE    8'hF0
`define DLF_CFG_GROUP    4'hA
`define DLF_HW_GROUP     4'hB
`define DLF_RUN_GROUP    4'hC

`define DLF_BYTES_PLAIN  3'h0
`define DLF_BYTES_SEGV   3'h4
`define DLF_BIT_MSB      3'h7

`define DLF_STAT_FAIL    0
`define DLF_STAT_READY   1
`define DLF_STAT_BUSY    2
`define DLF_STAT_RUN     3

`endif

// ---- rtl/dlf_pkg.sv ----
// types shared by the status indicator flasher
package dlf_pkg;

  typedef enum logic [1:0] {ST_TEST, ST_READY, ST_RUN, ST_FAULT} dlf_state_t;

  typedef enum logic [1:0] {PH_PULSE, PH_GAP, PH_PAUSE} dlf_phase_t;

  typedef enum logic [2:0] {CL_NONE, CL_WARN, CL_CFG, CL_HW, CL_RUN} dlf_class_t;

  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} dlf_ser_t;

  typedef struct packed {
    logic        valid;
    logic        steady;
    logic [7:0]  code;
    logic [31:0] faultLoc;
  } dlf_err_t;

endpackage

// ---- rtl/dlf_serial_port.sv ----
// 7N1 serial receiver and transmitter for the diagnostic terminal
`timescale 1ns/1ps
`include "dlf_params.svh"

module dlf_serial_port #(
  parameter logic [31:0] BIT_CYC = `DLF_BAUD_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       rxdPin,
  input  wire logic       txValid,
  input  wire logic [6:0] txData,
  output logic            txReady,
  output logic            rxValid,
  output logic [6:0]      rxData,
  output logic            txdPin
);
  import dlf_pkg::*;

  logic        rxS1_q;
  logic        rxS2_q;
  dlf_ser_t    rxSt_q;
  logic [31:0] rxCnt_q;
  logic [2:0]  rxBit_q;
  logic        txBusy_q;
  logic [8:0]  txSh_q;
  logic [31:0] txCnt_q;
  logic [3:0]  txBit_q;

  wire rxTick = (rxCnt_q == 32'h0);
  wire txTick = (txCnt_q == 32'h0);
  wire txLoad = txValid && !txBusy_q;

  always_ff @(posedge mclk)
  begin
    rxS1_q <= rxdPin;
    rxS2_q <= rxS1_q;
  end

  // receive: centre sampling from the start edge
  always_ff @(posedge mclk)
  begin
    rxValid <= 1'b0;
    if (sys_rst)
    begin
      rxSt_q  <= SER_IDLE;
      rxCnt_q <= 32'h0;
      rxBit_q <= 3'h0;
      rxData  <= 7'h00;
    end
    else
    begin
      rxCnt_q <= rxTick ? BIT_CYC - 32'h1 : rxCnt_q - 32'h1;
      unique case (rxSt_q)
        SER_IDLE:
          if (!rxS2_q)
          begin
            rxSt_q  <= SER_START;
            rxCnt_q <= BIT_CYC >> 1;
          end
        SER_START:
          if (rxTick)
          begin
            rxSt_q  <= rxS2_q ? SER_IDLE : SER_DATA;
            rxBit_q <= 3'h0;
          end
        SER_DATA:
          if (rxTick)
          begin
            rxData  <= {rxS2_q, rxData[6:1]};
            rxBit_q <= rxBit_q + 3'h1;
            if (rxBit_q == `DLF_SER_LAST)
              rxSt_q <= SER_STOP;
          end
        SER_STOP:
          if (rxTick)
          begin
            rxValid <= rxS2_q; // RL14
            rxSt_q  <= SER_IDLE;
          end
      endcase
    end
  end

  // transmit: start bit, 7 data bits lsb first, stop bit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      txBusy_q <= 1'b0;
      txSh_q   <= 9'h1FF;
      txCnt_q  <= 32'h0;
      txBit_q  <= 4'h0;
      txdPin   <= 1'b1;
    end
    else if (txLoad)
    begin
      txBusy_q <= 1'b1;
      txSh_q   <= {1'b1, txData, 1'b0}; // RL14
      txCnt_q  <= BIT_CYC - 32'h1;
      txBit_q  <= 4'h0;
      txdPin   <= 1'b0;
    end
    else if (txBusy_q)
    begin
      txCnt_q <= txTick ? BIT_CYC - 32'h1 : txCnt_q - 32'h1;
      if (txTick)
      begin
        txSh_q  <= {1'b1, txSh_q[8:1]};
        txdPin  <= txSh_q[1];
        txBit_q <= txBit_q + 4'h1;
        if (txBit_q == `DLF_SER_FRAME)
        begin
          txBusy_q <= 1'b0;
          txdPin   <= 1'b1;
        end
      end
    end
  end

  assign txReady = !txBusy_q;

endmodule

// ---- bench/dlf_term_model.sv ----
// terminal model: sends characters to the device and collects its replies
`timescale 1ns/1ps

module dlf_term_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic mclk,
  input  wire logic fromDev,
  output logic      toDev
);
  logic [6:0] gotQ[$];

  // idle line rests high, as with a pull-up
  initial toDev = 1'b1;

  // one 7N1 frame, start bit, data lsb first, stop bit
  task automatic send_char(input logic [6:0] ch);
    logic [8:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      toDev = frame[i];
      repeat (BIT_CYC) @(posedge mclk);
      #1;
    end
  endtask

  // receiver samples mid-bit; a bad stop bit is logged as 7F
  always
  begin : rxLoop
    logic [6:0] ch;
    @(negedge fromDev);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 7; i++)
    begin
      repeat (BIT_CYC) @(posedge mclk);
      ch[i] = fromDev;
    end
    repeat (BIT_CYC) @(posedge mclk);
    if (fromDev === 1'b1)
      gotQ.push_back(ch);
    else
      gotQ.push_back(7'h7F);
  end
endmodule

// ---- bench/dlf_tb.sv ----
// self-checking bench for the status indicator flasher
`timescale 1ns/1ps

module tb;
  import dlf_pkg::*;
  localparam int TEST_C = 600;
  localparam int LONG_C = 12;
  localparam int SHORT_C = 4;
  localparam int GAP_C = 6;
  localparam int PAUSE_C = 30;
  localparam int BLINK_C = 10;
  localparam int BAUD_C = 16;

  logic     mclk = 1'b0;
  logic     sys_rst = 1'b1;
  logic     hostSwRst = 1'b0;
  logic     cfgAccepted = 1'b0;
  dlf_err_t errIn = '0;
  logic     uartRxd;
  logic     status_led;
  logic [7:0] portAStatus;
  logic [7:0] portBStatus;
  logic     uartTxd;
  int       num_errors = 0;
  int       checks = 0;

  always #4 mclk = ~mclk;

  dlf_flasher #(.TEST_CYC(TEST_C), .LONG_CYC(LONG_C), .SHORT_CYC(SHORT_C), .GAP_CYC(GAP_C),
    .PAUSE_CYC(PAUSE_C), .BLINK_CYC(BLINK_C), .BAUD_CYC(BAUD_C)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .hostSwRst(hostSwRst), .cfgAccepted(cfgAccepted),
    .errIn(errIn), .uartRxd(uartRxd), .status_led(status_led), .portAStatus(portAStatus),
    .portBStatus(portBStatus), .uartTxd(uartTxd));

  dlf_term_model #(.BIT_CYC(BAUD_C)) term (.mclk(mclk), .fromDev(uartTxd), .toDev(uartRxd));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask

  task automatic timeout(input string msg);
    chk(1'b0, msg);
    report_and_stop();
  endtask

  // inputs change 1 ns after the rising edge, outputs are read there too
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input logic sw);
    sys_rst = !sw;
    hostSwRst = sw;
    step(5);
    sys_rst = 1'b0;
    hostSwRst = 1'b0;
    step(1);
    chk(status_led === 1'b1 && portAStatus === 8'h04, "reset state");
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (portAStatus !== 8'h02 && n < TEST_C + 20)
    begin
      step(1);
      n++;
    end
    if (n >= TEST_C + 20) timeout("never ready");
  endtask

  task automatic send_err(input logic [7:0] c, input logic st, input logic [31:0] loc);
    errIn = '{valid: 1'b1, steady: st, code: c, faultLoc: loc};
    step(1);
    errIn.valid = 1'b0;
  endtask

  task automatic run_len(input logic lvl, output int len);
    len = 0;
    while (status_led === lvl && len < 1000)
    begin
      step(1);
      len++;
    end
    if (len >= 1000) timeout("led stuck");
  endtask

  task automatic sync_pause();
    int low;
    low = 0;
    for (int i = 0; i < 3000 && low < GAP_C + 10; i++)
    begin
      step(1);
      low = (status_led === 1'b0) ? low + 1 : 0;
    end
    if (low < GAP_C + 10) timeout("no pause seen");
  endtask

  // reads one full repetition after a pause, msb first
  task automatic check_code(input int nb, input logic [39:0] exp);
    logic [39:0] got;
    int len;
    got = '0;
    sync_pause();
    for (int i = 0; i < nb * 8; i++)
    begin
      run_len(1'b0, len);
      chk(i == 0 || len < PAUSE_C, "pause inside code");
      run_len(1'b1, len);
      got = {got[38:0], len == LONG_C};
      chk(len == LONG_C || len == SHORT_C, "pulse length");
    end
    run_len(1'b0, len);
    chk(len >= PAUSE_C, "no pause after code");
    chk(got === exp, "flashed code");
  endtask

  task automatic go_run();
    int n;
    do_reset(1'b1);
    wait_ready(n);
    chk(n >= TEST_C - 3 && n <= TEST_C + 3, "self-test length");
    cfgAccepted = 1'b1;
    step(1);
    cfgAccepted = 1'b0;
    step(1);
    chk(status_led === 1'b0 && portBStatus === 8'h08, "configured");
  endtask

  task automatic t_selftest();
    logic ok;
    int a;
    int b;
    do_reset(1'b0);
    send_err(8'hC0, 1'b0, '0);
    cfgAccepted = 1'b1;
    step(1);
    cfgAccepted = 1'b0;
    ok = 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      step(1);
      if (status_led !== 1'b1 || portAStatus !== 8'h04) ok = 1'b0;
    end
    chk(ok, "led or status during self-test");
    wait_ready(a);
    chk(portBStatus === 8'h02 && portAStatus[0] === 1'b0, "ready status");
    run_len(status_led, a);
    run_len(status_led, a);
    run_len(status_led, a);
    run_len(status_led, b);
    chk(a == BLINK_C && b == BLINK_C, "even blink");
    $display("test selftest done");
  endtask

  task automatic t_run();
    logic [7:0] codes[3] = '{8'hC0, 8'h91, 8'hCF};
    logic ok;
    foreach (codes[k])
    begin
      go_run();
      ok = 1'b1;
      for (int i = 0; i < 50; i++)
      begin
        step(1);
        if (status_led !== 1'b0) ok = 1'b0;
      end
      chk(ok, "led stays off");
      send_err(codes[k], 1'b0, '0);
      check_code(1, {32'h0, codes[k]});
    end
    go_run();
    send_err(8'hF0, 1'b0, 32'h1234ABCD);
    check_code(5, 40'hF01234ABCD);
    $display("test run done");
  endtask

  task automatic t_warn();
    logic [7:0] codes[3] = '{8'h70, 8'h71, 8'h72};
    int n;
    foreach (codes[k])
    begin
      do_reset(1'b0);
      step(10);
      send_err(codes[k], 1'b0, '0);
      check_code(1, {32'h0, codes[k]});
      wait_ready(n);
      chk(portAStatus === 8'h02, "warning kept self-test");
    end
    $display("test warn done");
  endtask

  task automatic t_hw();
    logic [6:0] exp[4] = '{7'h42, 7'h31, 7'h0D, 7'h0A};
    int n;
    do_reset(1'b0);
    step(5);
    errIn = '{valid: 1'b1, steady: 1'b0, code: 8'hB1, faultLoc: 32'h0};
    step(1);
    send_err(8'hA0, 1'b0, '0);
    step(2);
    chk(portAStatus[0] === 1'b1 && portBStatus[0] === 1'b1, "fail bit");
    check_code(1, 40'hB1);
    term.gotQ.delete();
    term.send_char(7'h3F);
    n = 0;
    while (term.gotQ.size() < 4 && n < 3000)
    begin
      step(1);
      n++;
    end
    if (n >= 3000) timeout("no terminal reply");
    foreach (exp[k]) chk(term.gotQ[k] === exp[k], "terminal text");
    $display("test hw done");
  endtask

  task automatic t_ready_err();
    logic [7:0] codes[3] = '{8'hA0, 8'hAE, 8'h88};
    logic ok;
    int n;
    foreach (codes[k])
    begin
      do_reset(1'b0);
      wait_ready(n);
      send_err(codes[k], 1'b0, '0);
      check_code(1, {32'h0, codes[k]});
    end
    do_reset(1'b0);
    wait_ready(n);
    send_err(8'hB5, 1'b1, '0);
    step(2);
    ok = 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      step(1);
      if (status_led !== 1'b1) ok = 1'b0;
    end
    chk(ok, "steady led");
    $display("test ready errors done");
  endtask

  initial
  begin
    t_selftest();
    t_run();
    t_warn();
    t_hw();
    t_ready_err();
    report_and_stop();
  end
endmodule
